// ---- rtl/bfw_pkg.sv ----
// Package of constants and carrier types for the bus-fault and wake interrupt sources
package bfw_pkg;

  localparam int BFW_DATA_W = 8;
  localparam int BFW_ADDR_W = 8;

  // Register offsets
  localparam logic [7:0] BFW_ADDR_IRQ_SUMMARY = 8'h07;
  localparam logic [7:0] BFW_ADDR_BUS_FAULT_SRC = 8'h08;
  localparam logic [7:0] BFW_ADDR_WAKE_THERMAL_SRC = 8'h09;

  // Reset values after supply power-on reset
  localparam logic [7:0] BFW_RST_IRQ_SUMMARY = 8'h00;
  localparam logic [7:0] BFW_RST_BUS_FAULT_SRC = 8'h00;
  localparam logic [3:0] BFW_RST_WAKE_THERMAL_SRC = 4'h0;
  localparam logic [7:0] BFW_RST_RD_DATA = 8'h00;

  // Summary register fields
  localparam int BFW_SUM_BUS_FAULT_BIT = 0;
  localparam int BFW_SUM_WAKE_THERMAL_BIT = 1;

  // Bus fault source fields
  localparam int BFW_BF_BUS_DOMINANT_BIT = 7;
  localparam int BFW_BF_TXD_RXD_SHORT_BIT = 6;
  localparam int BFW_BF_RXD_RECESSIVE_BIT = 5;
  localparam int BFW_BF_TXD_DOMINANT_BIT = 4;
  localparam int BFW_BF_CANL_SUPPLY_BIT = 3;
  localparam int BFW_BF_CANL_GROUND_BIT = 2;
  localparam int BFW_BF_CANH_GROUND_BIT = 1;
  localparam int BFW_BF_CANH_SUPPLY_BIT = 0;
  localparam int BFW_BF_W = 8;

  // Wake and thermal source fields; bits above are reserved
  localparam int BFW_WT_TEMP_RECOVER_BIT = 3;
  localparam int BFW_WT_TEMP_WARN_BIT = 2;
  localparam int BFW_WT_LOCAL_WAKE_BIT = 1;
  localparam int BFW_WT_REMOTE_WAKE_BIT = 0;
  localparam int BFW_WT_W = 4;

  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [BFW_ADDR_W-1:0] addr;
    logic [BFW_DATA_W-1:0] wdata;
  } bfw_req_s;

  // Bus and local pin fault detector levels
  typedef struct packed {
    logic bus_dominant;
    logic txd_rxd_short;
    logic rxd_recessive;
    logic txd_dominant;
    logic canl_supply;
    logic canl_ground;
    logic canh_ground;
    logic canh_supply;
  } bfw_bus_fault_s;

  // Wake and junction temperature detector levels
  typedef struct packed {
    logic temp_recover;
    logic temp_warn;
    logic local_wake;
    logic remote_wake;
  } bfw_wake_thermal_s;

endpackage

// ---- rtl/bfw_flag_bank.sv ----
// Bank of sticky interrupt flags set on a rising detector level
`timescale 1ns/1ps
module bfw_flag_bank
  import bfw_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] cond_i,
  input wire logic [WIDTH-1:0] clear_i,
  output logic [WIDTH-1:0] flags_o
);

  if (WIDTH < 1 || WIDTH > BFW_DATA_W)
  begin : g_bad_width
    $error("bfw_flag_bank: WIDTH must be 1 to 8");
  end

  logic [WIDTH-1:0] cond_prev_reg;
  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;
  logic [WIDTH-1:0] event_w;

  //////////////////////////////////////////////////////////////////////////////
  // Event detection on the rising edge of each detector level

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      cond_prev_reg <= '0;
    else
      cond_prev_reg <= cond_i;
  end

  assign event_w = cond_i & ~cond_prev_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Sticky flags: a fresh event beats a clear in the same cycle

  always_comb
  begin
    flags_next = (flags_reg & ~clear_i) | event_w;
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      flags_reg <= RESET_VALUE;
    else
      flags_reg <= flags_next;
  end

  assign flags_o = flags_reg;

endmodule // bfw_flag_bank

// ---- rtl/bfw_irq_sources.sv ----
// Bus-fault and wake/thermal interrupt source registers with summary bits
//
// Functional notes
// - Bit 7 of 0x08: bus stuck dominant
// - Bit 6 of 0x08: TxD/RxD short
// - Bit 5 of 0x08: RxD held recessive
// - Bit 4 of 0x08: TxD held dominant
// - Bit 3 of 0x08: CANL shorted to supply
// - Bit 2 of 0x08: CANL shorted to ground
// - Bit 1 of 0x08: CANH shorted to ground
// - Bit 0 of 0x08: CANH shorted to supply
// - Bit 3 of 0x09: temperature recovered
// - Bit 2 of 0x09: temperature warning exceeded
// - Bit 1 of 0x09: local wake on pin
// - Bit 0 of 0x09: remote wake by bus
// - Summary bit 0: any bus fault pending
// - Summary bit 1: any wake/thermal pending
`timescale 1ns/1ps
module bfw_irq_sources
  import bfw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire bfw_req_s req_i,
  input wire bfw_bus_fault_s bus_fault_i,
  input wire bfw_wake_thermal_s wake_thermal_i,
  output logic [BFW_DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic bus_fault_pending_o,
  output logic wake_thermal_pending_o
);

  logic [BFW_BF_W-1:0] bf_cond_w;
  logic [BFW_WT_W-1:0] wt_cond_w;
  logic [BFW_BF_W-1:0] bf_clear_w;
  logic [BFW_WT_W-1:0] wt_clear_w;
  logic [BFW_BF_W-1:0] bf_flags_w;
  logic [BFW_WT_W-1:0] wt_flags_w;
  logic [BFW_DATA_W-1:0] summary_w;
  logic [BFW_DATA_W-1:0] rd_data_next;
  logic [BFW_DATA_W-1:0] rd_data_reg;
  logic rd_valid_reg;
  logic bf_pending_reg;
  logic wt_pending_reg;
  logic wr_bf_hit_w;
  logic wr_wt_hit_w;

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration checks: the field map must fit the byte-wide register port

  if (BFW_BF_W != BFW_DATA_W)
  begin : g_bad_bf_width
    $error("bfw_irq_sources: bus fault flags must fill the data byte");
  end

  if (BFW_WT_W < 1 || BFW_WT_W >= BFW_DATA_W)
  begin : g_bad_wt_width
    $error("bfw_irq_sources: wake/thermal flag count out of range");
  end

  if (BFW_BF_BUS_DOMINANT_BIT >= BFW_BF_W || BFW_BF_TXD_RXD_SHORT_BIT >= BFW_BF_W ||
      BFW_BF_RXD_RECESSIVE_BIT >= BFW_BF_W || BFW_BF_TXD_DOMINANT_BIT >= BFW_BF_W ||
      BFW_BF_CANL_SUPPLY_BIT >= BFW_BF_W || BFW_BF_CANL_GROUND_BIT >= BFW_BF_W ||
      BFW_BF_CANH_GROUND_BIT >= BFW_BF_W || BFW_BF_CANH_SUPPLY_BIT >= BFW_BF_W)
  begin : g_bad_bf_field
    $error("bfw_irq_sources: bus fault field outside its register");
  end

  if (BFW_WT_TEMP_RECOVER_BIT >= BFW_WT_W || BFW_WT_TEMP_WARN_BIT >= BFW_WT_W ||
      BFW_WT_LOCAL_WAKE_BIT >= BFW_WT_W || BFW_WT_REMOTE_WAKE_BIT >= BFW_WT_W)
  begin : g_bad_wt_field
    $error("bfw_irq_sources: wake/thermal field outside its register");
  end

  if (BFW_SUM_BUS_FAULT_BIT >= BFW_DATA_W || BFW_SUM_WAKE_THERMAL_BIT >= BFW_DATA_W ||
      BFW_SUM_BUS_FAULT_BIT == BFW_SUM_WAKE_THERMAL_BIT)
  begin : g_bad_sum_field
    $error("bfw_irq_sources: summary fields overlap or overflow");
  end

  if (BFW_ADDR_IRQ_SUMMARY == BFW_ADDR_BUS_FAULT_SRC ||
      BFW_ADDR_IRQ_SUMMARY == BFW_ADDR_WAKE_THERMAL_SRC ||
      BFW_ADDR_BUS_FAULT_SRC == BFW_ADDR_WAKE_THERMAL_SRC)
  begin : g_bad_addr_map
    $error("bfw_irq_sources: register offsets collide");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write decode; writes to the summary or to unmapped offsets hit nothing

  always_comb
  begin
    wr_bf_hit_w = req_i.wr && (req_i.addr == BFW_ADDR_BUS_FAULT_SRC);
    wr_wt_hit_w = req_i.wr && (req_i.addr == BFW_ADDR_WAKE_THERMAL_SRC);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Detector levels mapped onto their flag positions

  always_comb
  begin
    bf_cond_w = '0;
    bf_cond_w[BFW_BF_BUS_DOMINANT_BIT] = bus_fault_i.bus_dominant;
    bf_cond_w[BFW_BF_TXD_RXD_SHORT_BIT] = bus_fault_i.txd_rxd_short;
    bf_cond_w[BFW_BF_RXD_RECESSIVE_BIT] = bus_fault_i.rxd_recessive;
    bf_cond_w[BFW_BF_TXD_DOMINANT_BIT] = bus_fault_i.txd_dominant;
    bf_cond_w[BFW_BF_CANL_SUPPLY_BIT] = bus_fault_i.canl_supply;
    bf_cond_w[BFW_BF_CANL_GROUND_BIT] = bus_fault_i.canl_ground;
    bf_cond_w[BFW_BF_CANH_GROUND_BIT] = bus_fault_i.canh_ground;
    bf_cond_w[BFW_BF_CANH_SUPPLY_BIT] = bus_fault_i.canh_supply;
  end

  always_comb
  begin
    wt_cond_w = '0;
    wt_cond_w[BFW_WT_TEMP_RECOVER_BIT] = wake_thermal_i.temp_recover;
    wt_cond_w[BFW_WT_TEMP_WARN_BIT] = wake_thermal_i.temp_warn;
    wt_cond_w[BFW_WT_LOCAL_WAKE_BIT] = wake_thermal_i.local_wake;
    wt_cond_w[BFW_WT_REMOTE_WAKE_BIT] = wake_thermal_i.remote_wake;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write one to clear; reserved bits of the wake/thermal register ignored

  always_comb
  begin
    bf_clear_w = '0;
    wt_clear_w = '0;
    if (wr_bf_hit_w)
      bf_clear_w = req_i.wdata;
    if (wr_wt_hit_w)
      wt_clear_w = req_i.wdata[BFW_WT_W-1:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flag banks

  bfw_flag_bank #(
    .WIDTH(BFW_BF_W),
    .RESET_VALUE(BFW_RST_BUS_FAULT_SRC)
  ) u_bus_fault_flags (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .cond_i(bf_cond_w),
    .clear_i(bf_clear_w),
    .flags_o(bf_flags_w)
  );

  bfw_flag_bank #(
    .WIDTH(BFW_WT_W),
    .RESET_VALUE(BFW_RST_WAKE_THERMAL_SRC)
  ) u_wake_thermal_flags (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .cond_i(wt_cond_w),
    .clear_i(wt_clear_w),
    .flags_o(wt_flags_w)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Summary bits, registered so that the outputs come from flip-flops
  // They trail the flags by one cycle, and a summary read sees the same copy

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      bf_pending_reg <= 1'b0;
    else
      bf_pending_reg <= |bf_flags_w;
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      wt_pending_reg <= 1'b0;
    else
      wt_pending_reg <= |wt_flags_w;
  end

  always_comb
  begin
    summary_w = BFW_RST_IRQ_SUMMARY;
    summary_w[BFW_SUM_BUS_FAULT_BIT] = bf_pending_reg;
    summary_w[BFW_SUM_WAKE_THERMAL_BIT] = wt_pending_reg;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped offsets answer zero
  // Read data is the state before this edge's update

  always_comb
  begin
    rd_data_next = BFW_RST_RD_DATA;
    unique case (req_i.addr)
      BFW_ADDR_IRQ_SUMMARY: rd_data_next = summary_w;
      BFW_ADDR_BUS_FAULT_SRC: rd_data_next = bf_flags_w;
      BFW_ADDR_WAKE_THERMAL_SRC: rd_data_next = {{(BFW_DATA_W-BFW_WT_W){1'b0}}, wt_flags_w};
      default: rd_data_next = BFW_RST_RD_DATA;
    endcase
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      rd_data_reg <= BFW_RST_RD_DATA;
    else if (req_i.rd)
      rd_data_reg <= rd_data_next;
  end

  always_ff @(posedge mclk_i or posedge reset_i)
  begin
    if (reset_i)
      rd_valid_reg <= 1'b0;
    else
      rd_valid_reg <= req_i.rd;
  end

  assign rd_data_o = rd_data_reg;
  assign rd_valid_o = rd_valid_reg;
  assign bus_fault_pending_o = bf_pending_reg;
  assign wake_thermal_pending_o = wt_pending_reg;

endmodule // bfw_irq_sources

// ---- verification/bfw_irq_checker.sv ----
// Checker for the interrupt source registers
`timescale 1ns/1ps
module bfw_irq_checker
  import bfw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire bfw_req_s req_i,
  input wire bfw_bus_fault_s bus_fault_i,
  input wire bfw_wake_thermal_s wake_thermal_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic bus_fault_pending_o,
  input wire logic wake_thermal_pending_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////
  a_rd_pulse: assert property (1 |=> rd_valid_o == $past(req_i.rd))
    else $error("read answer pulse wrong");
  a_bf_rise_pend: assert property (|(bus_fault_i & ~$past(bus_fault_i)) |-> ##2 bus_fault_pending_o)
    else $error("bus fault event not pending");
  a_wt_rise_pend: assert property (|(wake_thermal_i & ~$past(wake_thermal_i)) |-> ##2 wake_thermal_pending_o)
    else $error("wake event not pending");
  a_bf_sticky: assert property ($fell(bus_fault_pending_o) |->
    $past(req_i.wr, 2) && $past(req_i.addr, 2) == BFW_ADDR_BUS_FAULT_SRC)
    else $error("bus fault pending fell without clear");
  a_wt_sticky: assert property ($fell(wake_thermal_pending_o) |->
    $past(req_i.wr, 2) && $past(req_i.addr, 2) == BFW_ADDR_WAKE_THERMAL_SRC)
    else $error("wake pending fell without clear");
  a_wt_resv_zero: assert property (req_i.rd && req_i.addr == BFW_ADDR_WAKE_THERMAL_SRC |=> rd_data_o[7:4] == 4'h0)
    else $error("reserved bits not zero");
  a_sum_read: assert property (req_i.rd && req_i.addr == BFW_ADDR_IRQ_SUMMARY |=>
    rd_data_o == {6'h00, $past(wake_thermal_pending_o), $past(bus_fault_pending_o)})
    else $error("summary read wrong");
  a_unmapped_zero: assert property (req_i.rd && req_i.addr > 8'h09 |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  c_bf_clear: cover property (req_i.wr && req_i.addr == BFW_ADDR_BUS_FAULT_SRC);
  c_wt_fall: cover property ($fell(wake_thermal_pending_o));
  c_rd_flag: cover property (rd_valid_o && rd_data_o != 8'h00);
  c_set_clear_race: cover property (req_i.wr && req_i.addr == BFW_ADDR_BUS_FAULT_SRC &&
    |(bus_fault_i & ~$past(bus_fault_i)));
endmodule // bfw_irq_checker
bind bfw_irq_sources bfw_irq_checker chk_i (.mclk_i(mclk_i), .reset_i(reset_i), .req_i(req_i),
  .bus_fault_i(bus_fault_i), .wake_thermal_i(wake_thermal_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .bus_fault_pending_o(bus_fault_pending_o), .wake_thermal_pending_o(wake_thermal_pending_o));

// ---- verification/bfw_host_model.sv ----
// Host model issuing register reads and writes
`timescale 1ns/1ps
module bfw_host_model
  import bfw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  output bfw_req_s req_o
);
  initial
  begin
    req_o = '0;
  end
  ////////////////////////////////////////
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req_o.rd = 1'b1;
    req_o.addr = a;
    @(posedge mclk_i);
    #1 req_o.rd = 1'b0;
    req_o.addr = ~a;
    d = rd_valid_i ? rd_data_i : 8'hXX;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req_o.wr = 1'b1;
    req_o.addr = a;
    req_o.wdata = v;
    @(posedge mclk_i);
    #1 req_o.wr = 1'b0;
    req_o.wdata = ~v;
    @(posedge mclk_i);
    #1;
  endtask
endmodule // bfw_host_model

// ---- verification/tb.sv ----
// Testbench for the interrupt source registers
`timescale 1ns/1ps
module tb
  import bfw_pkg::*;
;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  bfw_req_s req;
  bfw_bus_fault_s bf = '0;
  bfw_wake_thermal_s wt = '0;
  logic [7:0] rdat;
  logic rval, bfp, wtp;
  int err_count = 0;
  int n_checks = 0;
  initial
  begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  bfw_host_model host (.mclk_i(mclk_i), .rd_data_i(rdat), .rd_valid_i(rval), .req_o(req));
  bfw_irq_sources dut (.mclk_i(mclk_i), .reset_i(reset_i), .req_i(req), .bus_fault_i(bf),
    .wake_thermal_i(wt), .rd_data_o(rdat), .rd_valid_o(rval), .bus_fault_pending_o(bfp),
    .wake_thermal_pending_o(wtp));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic lvl(input logic [7:0] a, input logic [7:0] m);
    if (a == BFW_ADDR_BUS_FAULT_SRC)
      bf = m;
    else
      wt = m[3:0];
  endtask
  // Set, hold after level drop, clear while level stays high
  task automatic src_bit(input logic [7:0] a, input int i);
    logic [7:0] d, m;
    m = 8'h01 << i;
    lvl(a, m);
    cyc(2);
    host.rd(a, d);
    chk("flag", m, d);
    host.rd(BFW_ADDR_IRQ_SUMMARY, d);
    chk("summary", (a == BFW_ADDR_BUS_FAULT_SRC) ? 8'h01 : 8'h02, d);
    lvl(a, 8'h00);
    cyc(1);
    host.rd(a, d);
    chk("sticky", m, d);
    lvl(a, m);
    cyc(1);
    host.wr(a, m);
    host.rd(a, d);
    chk("cleared", 8'h00, d);
    chk("pending", 8'h00, {7'h00, (a == BFW_ADDR_BUS_FAULT_SRC) ? bfp : wtp});
    lvl(a, 8'h00);
    cyc(1);
  endtask
  task automatic t_reset();
    logic [7:0] d;
    for (int a = 7; a <= 12; a++)
    begin
      host.rd(8'(a), d);
      chk("reset value", 8'h00, d);
    end
  endtask
  task automatic t_bus();
    for (int i = 0; i < 8; i++)
      src_bit(BFW_ADDR_BUS_FAULT_SRC, i);
  endtask
  task automatic t_wake();
    for (int i = 0; i < 4; i++)
      src_bit(BFW_ADDR_WAKE_THERMAL_SRC, i);
  endtask
  task automatic t_resv();
    logic [7:0] d;
    wt = 4'hF;
    cyc(2);
    host.wr(BFW_ADDR_WAKE_THERMAL_SRC, 8'hF0);
    host.wr(BFW_ADDR_IRQ_SUMMARY, 8'hFF);
    host.rd(BFW_ADDR_WAKE_THERMAL_SRC, d);
    chk("reserved", 8'h0F, d);
    host.wr(BFW_ADDR_WAKE_THERMAL_SRC, 8'hFF);
    host.rd(BFW_ADDR_WAKE_THERMAL_SRC, d);
    chk("all cleared", 8'h00, d);
    wt = 4'h0;
  endtask
  // Event and clear land on one edge: the event wins
  task automatic t_race();
    logic [7:0] d;
    bf = 8'h80;
    cyc(1);
    bf = 8'h00;
    cyc(1);
    fork
      host.wr(BFW_ADDR_BUS_FAULT_SRC, 8'h80);
      bf = 8'h80;
    join
    host.rd(BFW_ADDR_BUS_FAULT_SRC, d);
    chk("set beats clear", 8'h80, d);
    bf = 8'h00;
    cyc(1);
    host.wr(BFW_ADDR_BUS_FAULT_SRC, 8'h80);
    host.rd(BFW_ADDR_BUS_FAULT_SRC, d);
    chk("race cleared", 8'h00, d);
  endtask
  initial
  begin
    #20000;
    err_count++;
    give_verdict();
  end
  initial
  begin
    repeat (8) @(posedge mclk_i);
    #1 reset_i = 1'b0;
    t_reset();
    t_bus();
    t_wake();
    t_resv();
    t_race();
    give_verdict();
  end
endmodule // tb
